// ### rtl/acb_pkg.sv
package acb_pkg;

  // Register map.
  localparam int          ADDR_W           = 16;
  localparam int          DATA_W           = 32;
  localparam logic [15:0] ANALOG_CONTROL_0 = 16'h0185;

  // Field positions inside analog_control_0.
  localparam int RC_CLOCK_POWERDOWN_BIT       = 29;
  localparam int BIAS_ENABLE_BIT              = 28;
  localparam int REFERENCE_ENABLE_BIT         = 27;
  localparam int CRYSTAL_STIMULATE_ENABLE_BIT = 21;

  // Values after reset.
  localparam logic RC_CLOCK_POWERDOWN_RST       = 1'b1;
  localparam logic BIAS_ENABLE_RST              = 1'b0;
  localparam logic REFERENCE_ENABLE_RST         = 1'b0;
  localparam logic CRYSTAL_STIMULATE_ENABLE_RST = 1'b0;

  // Stimulus timing, counted in slow RC clock edges.
  localparam int SLOW_RC_CLOCK_HZ = 32000;
  localparam int STIM_PERIOD_MS   = 1000;
  localparam int STIM_WIDTH_MS    = 1;
  localparam int STIM_PERIOD_EDGES = SLOW_RC_CLOCK_HZ / 1000 * STIM_PERIOD_MS;
  localparam int STIM_WIDTH_EDGES  = SLOW_RC_CLOCK_HZ / 1000 * STIM_WIDTH_MS;
  localparam int STIM_CNT_W        = 16;

  // Operating mode codes on the mode input.
  localparam logic [1:0] MODE_IN_METERING = 2'h0;
  localparam logic [1:0] MODE_IN_SLEEP    = 2'h1;
  localparam logic [1:0] MODE_IN_DETECT   = 2'h2;

  typedef enum logic [2:0] {
    ACB_METERING = 3'b001,
    ACB_SLEEP    = 3'b010,
    ACB_DETECT   = 3'b100
  } acb_mode_type;

endpackage : acb_pkg

// ### rtl/acb_stimulator.sv
`timescale 1ns/1ns
module acb_stimulator
  import acb_pkg::*;
#(
  parameter int PERIOD_EDGES = STIM_PERIOD_EDGES,
  parameter int WIDTH_EDGES  = STIM_WIDTH_EDGES
) (
  // Clock and reset.
  input  wire logic clk_sys,
  input  wire logic nrst,
  // Control.
  input  wire logic slow_rise,
  input  wire logic stim_active,
  // Stimulus.
  output logic      stim_pulse_q
);

  logic [STIM_CNT_W-1:0] cnt_q;

  ////////////////////////////////////////////////////////////////////////////
  // Counts slow clock edges over one stimulus period while active.
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      cnt_q <= '0;
    end else if (!stim_active) begin
      cnt_q <= '0;
    end else if (slow_rise) begin
      if (cnt_q == STIM_CNT_W'(PERIOD_EDGES - 1)) begin
        cnt_q <= '0;
      end else begin
        cnt_q <= cnt_q + STIM_CNT_W'(1);
      end
    end
  end

  // The pulse covers the first edges of each period.
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      stim_pulse_q <= 1'b0;
    end else begin
      stim_pulse_q <= stim_active && (cnt_q < STIM_CNT_W'(WIDTH_EDGES)); // [RQ14]
    end
  end

endmodule : acb_stimulator

// ### rtl/acb_control.sv
//
// Behaviour
// (RQ1) Power-down bit zero runs the RC oscillator; one powers it down.
// (RQ2) Power-down bit has no documented reset value; do not rely on it.
// (RQ3) Host enables reference and bias before clearing power-down.
// (RQ4) Sleep entry sets power-down; current-detection entry clears it.
// (RQ5) Host should keep RC oscillator powered down in full metering.
// (RQ6) Bias-enable one turns on global bias current; zero keeps it off.
// (RQ7) Bias-enable resets to zero.
// (RQ8) Reference-enable one turns on the reference; resets to zero.
// (RQ9) Host sets bias and reference before enabling ADCs or RC oscillator.
// (RQ10) Sleep entry clears bias and reference; detection entry sets both.
// (RQ11) Stimulate-enable one restarts a stopped crystal with stimulation.
// (RQ12) Stimulate-enable resets to zero.
// (RQ13) Host should set stimulate-enable in full metering mode.
// (RQ14) Stopped crystal with stimulation on: 1 ms pulse every second.
// (RQ15) Metering mode runs RC oscillator while the crystal is stopped.
// (RQ16) Mode-entry changes act in the entry cycle and override writes.
`timescale 1ns/1ns
module acb_control
  import acb_pkg::*;
#(
  parameter int PERIOD_EDGES = STIM_PERIOD_EDGES,
  parameter int WIDTH_EDGES  = STIM_WIDTH_EDGES
) (
  // Clock and reset.
  input  wire logic              clk_sys,
  input  wire logic              nrst,
  // Register port.
  input  wire logic [ADDR_W-1:0] reg_addr,
  input  wire logic [DATA_W-1:0] reg_wdata,
  input  wire logic              reg_wr,
  input  wire logic              reg_rd,
  output logic      [DATA_W-1:0] reg_rdata_q,
  // Operating mode.
  input  wire logic [1:0]        op_mode,
  // Asynchronous inputs.
  input  wire logic              slow_rc_clock,
  input  wire logic              crystal_running,
  // Analog controls.
  output logic                   rc_osc_run_q,
  output logic                   bias_on_q,
  output logic                   reference_on_q,
  output logic                   crystal_stimulus_q
);

  ////////////////////////////////////////////////////////////////////////////
  // Three-stage filter: a change counts once stages two and three agree.
  function automatic logic filt(input logic s2, input logic s3,
                                input logic lvl);
    filt = (s2 == s3) ? s2 : lvl;
  endfunction : filt

  logic [2:0]   slow_sync_q;
  logic [2:0]   xtal_sync_q;
  logic         slow_lvl_q;
  logic         xtal_lvl_q;
  logic         slow_rise;
  logic         xtal_stopped;

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      slow_sync_q <= 3'h0;
      slow_lvl_q  <= 1'b0;
    end else begin
      slow_sync_q <= {slow_sync_q[1:0], slow_rc_clock};
      slow_lvl_q  <= filt(slow_sync_q[1], slow_sync_q[2], slow_lvl_q);
    end
  end

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      xtal_sync_q <= 3'h7;
      xtal_lvl_q  <= 1'b1;
    end else begin
      xtal_sync_q <= {xtal_sync_q[1:0], crystal_running};
      xtal_lvl_q  <= filt(xtal_sync_q[1], xtal_sync_q[2], xtal_lvl_q);
    end
  end

  assign slow_rise    = !slow_lvl_q &&
                        filt(slow_sync_q[1], slow_sync_q[2], slow_lvl_q);
  assign xtal_stopped = !xtal_lvl_q;

  ////////////////////////////////////////////////////////////////////////////
  // Mode tracking and entry detection.
  acb_mode_type mode_q;
  acb_mode_type mode_d;
  logic         enter_sleep;
  logic         enter_detect;

  always_comb begin
    case (op_mode)
      MODE_IN_SLEEP:  mode_d = ACB_SLEEP;
      MODE_IN_DETECT: mode_d = ACB_DETECT;
      default:        mode_d = ACB_METERING;
    endcase
  end

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      mode_q <= ACB_METERING;
    end else begin
      mode_q <= mode_d;
    end
  end

  assign enter_sleep  = (mode_d == ACB_SLEEP) && (mode_q != ACB_SLEEP);
  assign enter_detect = (mode_d == ACB_DETECT) && (mode_q != ACB_DETECT);

  ////////////////////////////////////////////////////////////////////////////
  // Register bits.
  logic rc_pd_q;
  logic bias_en_q;
  logic ref_en_q;
  logic stim_en_q;
  logic wr_hit;

  assign wr_hit = reg_wr && (reg_addr == ANALOG_CONTROL_0);

  // Power-down bit; its reset value is a fixed choice only. [RQ2]
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      rc_pd_q <= RC_CLOCK_POWERDOWN_RST;
    end else if (enter_sleep) begin
      rc_pd_q <= 1'b1; // [RQ4] [RQ16]
    end else if (enter_detect) begin
      rc_pd_q <= 1'b0; // [RQ4] [RQ16]
    end else if (wr_hit) begin
      rc_pd_q <= reg_wdata[RC_CLOCK_POWERDOWN_BIT];
    end
  end

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      bias_en_q <= BIAS_ENABLE_RST; // [RQ7]
    end else if (enter_sleep) begin
      bias_en_q <= 1'b0; // [RQ10] [RQ16]
    end else if (enter_detect) begin
      bias_en_q <= 1'b1; // [RQ10] [RQ16]
    end else if (wr_hit) begin
      bias_en_q <= reg_wdata[BIAS_ENABLE_BIT];
    end
  end

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      ref_en_q <= REFERENCE_ENABLE_RST; // [RQ8]
    end else if (enter_sleep) begin
      ref_en_q <= 1'b0; // [RQ10] [RQ16]
    end else if (enter_detect) begin
      ref_en_q <= 1'b1; // [RQ10] [RQ16]
    end else if (wr_hit) begin
      ref_en_q <= reg_wdata[REFERENCE_ENABLE_BIT];
    end
  end

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      stim_en_q <= CRYSTAL_STIMULATE_ENABLE_RST; // [RQ12]
    end else if (wr_hit) begin
      stim_en_q <= reg_wdata[CRYSTAL_STIMULATE_ENABLE_BIT];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read port: data stand one cycle after the strobe; other addresses read 0.
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      reg_rdata_q <= '0;
    end else if (reg_rd && (reg_addr == ANALOG_CONTROL_0)) begin
      reg_rdata_q <= '0;
      reg_rdata_q[RC_CLOCK_POWERDOWN_BIT]       <= rc_pd_q;
      reg_rdata_q[BIAS_ENABLE_BIT]              <= bias_en_q;
      reg_rdata_q[REFERENCE_ENABLE_BIT]         <= ref_en_q;
      reg_rdata_q[CRYSTAL_STIMULATE_ENABLE_BIT] <= stim_en_q;
    end else begin
      reg_rdata_q <= '0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Analog control outputs.
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      rc_osc_run_q <= 1'b0;
    end else if ((mode_q == ACB_METERING) && xtal_stopped) begin
      rc_osc_run_q <= 1'b1; // [RQ15]
    end else begin
      rc_osc_run_q <= !rc_pd_q; // [RQ1]
    end
  end

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      bias_on_q      <= 1'b0;
      reference_on_q <= 1'b0;
    end else begin
      bias_on_q      <= bias_en_q; // [RQ6]
      reference_on_q <= ref_en_q; // [RQ8]
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Crystal restart stimulation.
  logic stim_active;

  assign stim_active = stim_en_q && xtal_stopped; // [RQ11]

  acb_stimulator #(
    .PERIOD_EDGES (PERIOD_EDGES),
    .WIDTH_EDGES  (WIDTH_EDGES)
  ) u_stim (
    .clk_sys      (clk_sys),
    .nrst         (nrst),
    .slow_rise    (slow_rise),
    .stim_active  (stim_active),
    .stim_pulse_q (crystal_stimulus_q)
  );

endmodule : acb_control

// ### tb/acb_control_assertions.sv
`timescale 1ns/1ns
module acb_control_checker
  import acb_pkg::*;
(
  // Clock and reset.
  input wire logic              clk_sys,
  input wire logic              nrst,
  // Register port.
  input wire logic [ADDR_W-1:0] reg_addr,
  input wire logic [DATA_W-1:0] reg_wdata,
  input wire logic              reg_wr,
  input wire logic              reg_rd,
  input wire logic [DATA_W-1:0] reg_rdata_q,
  // Mode and asynchronous inputs.
  input wire logic [1:0]        op_mode,
  input wire logic              slow_rc_clock,
  input wire logic              crystal_running,
  // Analog controls.
  input wire logic              rc_osc_run_q,
  input wire logic              bias_on_q,
  input wire logic              reference_on_q,
  input wire logic              crystal_stimulus_q
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!nrst);
  logic hit;
  assign hit = reg_wr && reg_addr == ANALOG_CONTROL_0 && op_mode == 2'h0;
  sleep_forcing_a: assert property ($changed(op_mode)
    && op_mode == MODE_IN_SLEEP |-> ##2 !bias_on_q && !reference_on_q
    && !rc_osc_run_q) else $error("Sleep entry did not clear controls.");
  detect_forcing_a: assert property ($changed(op_mode)
    && op_mode == MODE_IN_DETECT |-> ##2 bias_on_q && reference_on_q
    && rc_osc_run_q) else $error("Detect entry did not set controls.");
  bias_write_a: assert property (hit && $stable(op_mode) |->
    ##2 bias_on_q == $past(reg_wdata[BIAS_ENABLE_BIT], 2))
    else $error("Bias output does not follow write.");
  ref_write_a: assert property (hit && $stable(op_mode) |->
    ##2 reference_on_q == $past(reg_wdata[REFERENCE_ENABLE_BIT], 2))
    else $error("Reference output does not follow write.");
  rc_write_a: assert property (hit && $stable(op_mode)
    && crystal_running && $past(crystal_running, 8) |->
    ##2 rc_osc_run_q == !$past(reg_wdata[RC_CLOCK_POWERDOWN_BIT], 2))
    else $error("Oscillator run does not follow power-down write.");
  unmapped_read_a: assert property (reg_rd &&
    reg_addr != ANALOG_CONTROL_0 |=> reg_rdata_q == '0)
    else $error("Unmapped read returned data.");
  reserved_zero_a: assert property (reg_rd |=>
    (reg_rdata_q & ~32'h38200000) == '0)
    else $error("Reserved bits read nonzero.");
  stim_quiet_a: assert property (crystal_running [*8] |=>
    !crystal_stimulus_q) else $error("Stimulus with crystal running.");
  meter_restart_a: assert property ((op_mode == 2'h0 &&
    !crystal_running) [*8] |=> rc_osc_run_q)
    else $error("Oscillator not started for stopped crystal.");
  cover property ($changed(op_mode) && op_mode == MODE_IN_SLEEP);
  cover property ($changed(op_mode) && op_mode == MODE_IN_DETECT);
  cover property ($rose(crystal_stimulus_q));
endmodule : acb_control_checker

bind acb_control acb_control_checker chk_i (.clk_sys(clk_sys), .nrst(nrst),
  .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
  .reg_rd(reg_rd), .reg_rdata_q(reg_rdata_q), .op_mode(op_mode),
  .slow_rc_clock(slow_rc_clock), .crystal_running(crystal_running),
  .rc_osc_run_q(rc_osc_run_q), .bias_on_q(bias_on_q),
  .reference_on_q(reference_on_q), .crystal_stimulus_q(crystal_stimulus_q));

// ### tb/test_analog_clock_bias_power_control.sv
`timescale 1ns/1ns
module test_analog_clock_bias_power_control
  import acb_pkg::*;
;
  logic clk_sys = 1'b0, nrst = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0;
  logic slow_rc_clock = 1'b0, crystal_running = 1'b1;
  logic [ADDR_W-1:0] reg_addr = '0;
  logic [DATA_W-1:0] reg_wdata = '0, reg_rdata_q, q;
  logic [1:0] op_mode = 2'h0;
  logic rc, bias, refon, stim;
  int errors = 0, total_checks = 0, w, p;
  localparam logic [31:0] M = 32'h38200000;
  localparam logic [15:0] A = ANALOG_CONTROL_0;
  localparam int PER = 20, WID = 3, SLW = 8;
  acb_control #(.PERIOD_EDGES(PER), .WIDTH_EDGES(WID)) dut (.clk_sys(clk_sys),
    .nrst(nrst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata_q(reg_rdata_q),
    .op_mode(op_mode), .slow_rc_clock(slow_rc_clock),
    .crystal_running(crystal_running), .rc_osc_run_q(rc),
    .bias_on_q(bias), .reference_on_q(refon), .crystal_stimulus_q(stim));
  initial begin
    forever #20 clk_sys = ~clk_sys;
  end
  always begin
    repeat (SLW / 2) @(posedge clk_sys);
    slow_rc_clock <= ~slow_rc_clock;
  end
  //////////////////////////////////////////////////////////////////////////
  task chk(input logic [31:0] g, input logic [31:0] e);
    total_checks++;
    if (g !== e) begin
      errors++;
      $display("mismatch t=%0t got %h exp %h", $time, g, e);
    end
  endtask : chk
  task wr(input logic [15:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
  endtask : wr
  task rd(input logic [15:0] a);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk_sys);
    reg_rd <= 1'b0;
    #1 q = reg_rdata_q;
  endtask : rd
  task mode(input logic [1:0] m);
    @(posedge clk_sys);
    op_mode <= m;
    repeat (3) @(posedge clk_sys);
    rd(A);
  endtask : mode
  task wt(input logic v, output int n);
    n = 0;
    while (stim !== v && n < 400) begin
      @(posedge clk_sys);
      #1;
      n++;
    end
  endtask : wt
  task results;
    $display("checks %0d errors %0d", total_checks, errors);
    if (errors == 0 && total_checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : results
  //////////////////////////////////////////////////////////////////////////
  task t_regs;
    rd(A);
    chk(q & 32'h18200000, 0);
    chk({bias, refon, stim}, 0);
    wr(A, '1);
    wr(16'h0186, 0);
    rd(A);
    chk(q, M);
    rd(16'h0186);
    chk(q, 0);
    chk({rc, bias, refon}, 3'b011);
    wr(A, 32'h18000000);
    repeat (2) @(posedge clk_sys);
    #1 chk(rc, 1);
  endtask : t_regs
  task t_modes;
    mode(MODE_IN_SLEEP);
    chk(q & M, 32'h20000000);
    chk({rc, bias, refon}, 3'b000);
    mode(MODE_IN_DETECT);
    chk(q & M, 32'h18000000);
    chk({rc, bias, refon}, 3'b111);
    mode(2'h3);
    chk(q & M, 32'h18000000);
    mode(MODE_IN_METERING);
    @(posedge clk_sys);
    op_mode <= MODE_IN_SLEEP;
    reg_addr <= A;
    reg_wdata <= 32'h18200000;
    reg_wr <= 1'b1;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
    rd(A);
    chk(q & M, 32'h20200000);
    mode(MODE_IN_METERING);
  endtask : t_modes
  task t_stim;
    wr(A, M);
    crystal_running <= 1'b0;
    repeat (12) @(posedge clk_sys);
    #1 chk(rc, 1);
    wt(1, w);
    wt(0, w);
    wt(1, p);
    wt(0, w);
    chk(p, (PER - WID) * SLW);
    chk(w, WID * SLW);
    @(posedge clk_sys);
    crystal_running <= 1'b1;
    repeat (12) @(posedge clk_sys);
    #1 chk({rc, stim}, 0);
  endtask : t_stim
  initial begin
    repeat (6) @(posedge clk_sys);
    nrst <= 1'b1;
    t_regs;
    t_modes;
    t_stim;
    results;
  end
  initial begin
    repeat (5000) @(posedge clk_sys);
    errors++;
    results;
  end
endmodule : test_analog_clock_bias_power_control
